// *** rtl/nor_bus_pkg.sv ***
// package: pin levels, operation codes and timing constants for the flash bus controller
`default_nettype none
package nor_bus_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int SECTOR_LSB = 12;
  // command register offsets (byte addresses)
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_ADDR = 4'h4;
  localparam logic [3:0] OFF_WDATA = 4'h8;
  localparam logic [3:0] OFF_RDATA = 4'hC;
  // control fields: [2:0] op, [3] wordMode, [4] protectLevel, [5] resetReq
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_WORD_BIT = 3;
  localparam int CTL_WP_BIT = 4;
  localparam int CTL_RST_BIT = 5;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_PROTECT = 3'h3;
  localparam logic [2:0] OP_UNPROTECT = 3'h4;
  // protect/unprotect address pattern: A6 select, A3..A0 = 0010
  localparam int PROT_SEL_BIT = 6;
  localparam logic [3:0] PROT_LOW_PAT = 4'h2;
  // timing: access/strobe time and reset pulse width, in ns
  localparam int CLK_NS = 8;
  localparam int ACCESS_NS = 70;
  localparam int WE_PULSE_NS = 35;
  localparam int RESET_PULSE_NS = 500;
  localparam int RECOVER_NS = 50;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [DATA_W-1:0] ZERO_DATA = 16'h0000;
  // state codes, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_READ = 6'h02, ST_WRITE = 6'h04,
    ST_PROT = 6'h08, ST_RESET = 6'h10, ST_RECOVER = 6'h20
  } state_t;
  // strobe group driven toward the flash
  typedef struct packed {
    logic chipSelN;
    logic outEnN;
    logic writeStrobeN;
    logic resetN;
    logic highVoltReset;
    logic writeProtN;
    logic byteModeN;
  } ctrl_pins_t;
endpackage : nor_bus_pkg
`default_nettype wire

// *** rtl/nor_flash_host.sv ***
// host-side controller that drives the parallel flash bus pins
// Function
// R1 - read: select low, output enable low, strobe high
// R2 - write: strobe and select low, enable high
// R3 - flash reads array after power-up and reset
// R4 - flash stays array-read until command written
// R5 - commands latch internally, no addressable location
// R6 - word mode: all sixteen data pins used
// R7 - byte mode: low byte, top pin addresses
// R8 - address range follows width; sector from bit 12
// R9 - program data width follows width select
// R10 - bypass program two writes, else four
// R11 - sector, multi-sector or whole-array erase
// R12 - identification codes on low eight pins
// R13 - status bits read during program/erase
// R14 - protect: high-voltage reset, A6 picks direction
// R15 - write-protect low keeps boot sector locked
// R16 - output enable high floats data pins
// R17 - reset aborts, floats outputs, ignores access
// R18 - standby floats outputs
// R19 - ready/busy stays busy during reset recovery
// R20 - illegal strobe mixes do nothing
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nor_flash_host
  import nor_bus_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] busAddr,
  input wire logic [31:0] busWrData,
  input wire logic busWrite,
  input wire logic busRead,
  output logic [31:0] busRdData,
  output ctrl_pins_t pins,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [DATA_W-1:0] dataOut,
  output logic [DATA_W-1:0] dataOe,
  input wire logic [DATA_W-1:0] dataIn,
  input wire logic ready_busy_n
);
  state_t state_reg;
  state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [2:0] op_reg;
  logic wordMode_reg;
  logic protectLevel_reg;
  logic [ADDR_W:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rdySync_reg;
  logic [DATA_W-1:0] dinMeta_reg;
  logic [DATA_W-1:0] dinSync_reg;
  logic cntDone;
  logic busy;

  assign cntDone = (cnt_reg == '0);
  assign busy = (state_reg != ST_IDLE);

  // pin inputs pass two flops before any logic reads them
  // ready/busy is trusted only from the second stage, so a slow rise cannot fool the recovery wait
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdySync_reg <= 2'h0;
      dinMeta_reg <= ZERO_DATA;
      dinSync_reg <= ZERO_DATA;
    end else begin
      rdySync_reg <= {rdySync_reg[0], ready_busy_n};
      dinMeta_reg <= dataIn;
      dinSync_reg <= dinMeta_reg;
    end
  end
  // software command registers; a start is refused while busy
  always_ff @(posedge core_clk) begin
    if (reset) begin
      op_reg <= OP_NONE;
      wordMode_reg <= 1'b1;
      protectLevel_reg <= 1'b1; // R15
      addr_reg <= '0;
      wdata_reg <= ZERO_DATA;
    end else begin
      // the op stays until recovery: the protect phase re-reads it every cycle for the direction bit
      if (state_reg == ST_RECOVER) op_reg <= OP_NONE;
      if (busWrite && busAddr == OFF_CTRL) begin
        wordMode_reg <= busWrData[CTL_WORD_BIT]; // R9
        protectLevel_reg <= busWrData[CTL_WP_BIT];
        if (!busy) op_reg <= busWrData[CTL_RST_BIT] ? OP_NONE : busWrData[CTL_OP_LSB +: 3];
      end
      if (busWrite && busAddr == OFF_ADDR) addr_reg <= busWrData[ADDR_W:0];
      if (busWrite && busAddr == OFF_WDATA) wdata_reg <= busWrData[DATA_W-1:0];
    end
  end

  // next state: one operation per start, reset goes through recovery
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (busWrite && busAddr == OFF_CTRL && busWrData[CTL_RST_BIT]) state_next = ST_RESET; // R17
        else if (op_reg == OP_READ) state_next = ST_READ;
        else if (op_reg == OP_WRITE) state_next = ST_WRITE;
        else if (op_reg == OP_PROTECT || op_reg == OP_UNPROTECT) state_next = ST_PROT;
      end
      ST_READ, ST_WRITE, ST_PROT: if (cntDone) state_next = ST_RECOVER;
      ST_RESET: if (cntDone) state_next = ST_RECOVER;
      ST_RECOVER: if (cntDone && rdySync_reg[1]) state_next = ST_IDLE; // R19
    endcase
  end

  // state and cycle counter
  // a phase lasts its count plus one cycle, since the exit edge is the one that sees zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_RESET;
      cnt_reg <= CNT_W'(RESET_CYC);
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        unique case (state_next)
          ST_READ: cnt_reg <= CNT_W'(ACCESS_CYC);
          ST_WRITE, ST_PROT: cnt_reg <= CNT_W'(WE_CYC);
          ST_RESET: cnt_reg <= CNT_W'(RESET_CYC);
          ST_RECOVER: cnt_reg <= CNT_W'(RECOVER_CYC);
          default: cnt_reg <= '0;
        endcase
      end else if (!cntDone) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // capture read data at the end of the access time
  // the synchronised copy lags the pins by two cycles, so the value kept is the pin level 64 ns after output enable falls, short of the 70 ns access time
  always_ff @(posedge core_clk) begin
    if (reset) rdata_reg <= ZERO_DATA;
    else if (state_reg == ST_READ && cntDone) // R12 R13
      rdata_reg <= wordMode_reg ? dinSync_reg : {8'h00, dinSync_reg[BYTE_W-1:0]}; // R7
  end

  // pin drive from registers; no state mixes output enable with write strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pins <= '{chipSelN: 1'b1, outEnN: 1'b1, writeStrobeN: 1'b1, resetN: 1'b0,
                highVoltReset: 1'b0, writeProtN: 1'b1, byteModeN: 1'b1};
      flashAddr <= '0;
      dataOut <= ZERO_DATA;
      dataOe <= ZERO_DATA;
    end else begin
      pins.chipSelN <= !(state_next inside {ST_READ, ST_WRITE, ST_PROT}); // R18
      pins.outEnN <= (state_next != ST_READ); // R1 R16
      pins.writeStrobeN <= !(state_next inside {ST_WRITE, ST_PROT}); // R2 R20
      pins.resetN <= (state_next != ST_RESET); // R3 R17
      pins.highVoltReset <= (state_next == ST_PROT); // R14
      pins.writeProtN <= protectLevel_reg; // R15
      pins.byteModeN <= wordMode_reg; // R6
      // R8: address pins carry bits 20:1 in both modes; byte mode adds bit 0 on the top data pin
      // select, strobe and address move on one edge: the flash takes the address as the strobe
      // falls and the data as it rises, and the data word stays put after the rise
      flashAddr <= addr_reg[ADDR_W:1];
      if (state_next == ST_PROT) begin
        flashAddr[SECTOR_LSB-1:0] <= '0;
        flashAddr[3:0] <= PROT_LOW_PAT; // R14
        flashAddr[PROT_SEL_BIT] <= (op_reg == OP_UNPROTECT);
      end
      // R4 R5 R10 R11: command cycles are plain writes issued by software
      dataOut <= wordMode_reg ? wdata_reg : {addr_reg[0], 7'h00, wdata_reg[BYTE_W-1:0]};
      if (state_next == ST_WRITE || state_next == ST_PROT) dataOe <= wordMode_reg ? 16'hFFFF : 16'h80FF;
      else if (!wordMode_reg) dataOe <= 16'h8000; // R7
      else dataOe <= ZERO_DATA;
    end
  end

  // register read port, data one cycle after strobe; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (reset) busRdData <= '0;
    else if (busRead) begin
      unique case (busAddr)
        OFF_CTRL: busRdData <= {24'h0, rdySync_reg[1], busy, protectLevel_reg, wordMode_reg, 1'b0, op_reg};
        OFF_ADDR: busRdData <= {11'h0, addr_reg};
        OFF_WDATA: busRdData <= {16'h0, wdata_reg};
        OFF_RDATA: busRdData <= {16'h0, rdata_reg};
        default: busRdData <= '0;
      endcase
    end
  end

  // pin-level checks on the registered levels the flash actually sees; chk_busy_hold checks the recovery state alone
  chk_read_strobes: assert property (@(posedge core_clk) disable iff (reset)
    !pins.outEnN |-> (!pins.chipSelN && pins.writeStrobeN)) else $error("read pins wrong"); // R1
  chk_write_strobes: assert property (@(posedge core_clk) disable iff (reset)
    !pins.writeStrobeN |-> (!pins.chipSelN && pins.outEnN)) else $error("write pins wrong"); // R2
  chk_reset_float: assert property (@(posedge core_clk) disable iff (reset)
    !pins.resetN |-> (pins.chipSelN && dataOe[7:0] == 8'h00)) else $error("access during reset"); // R17
  chk_oe_release: assert property (@(posedge core_clk) disable iff (reset)
    !pins.outEnN |-> dataOe[7:0] == 8'h00) else $error("contention on read"); // R16
  chk_prot_voltage: assert property (@(posedge core_clk) disable iff (reset)
    pins.highVoltReset |-> (!pins.writeStrobeN && flashAddr[3:0] == PROT_LOW_PAT)) else $error("bad protect"); // R14
  chk_byte_lanes: assert property (@(posedge core_clk) disable iff (reset)
    !pins.byteModeN |-> dataOe[14:8] == 7'h00) else $error("byte lanes driven"); // R7
  chk_wp_follow: assert property (@(posedge core_clk) disable iff (reset)
    pins.writeProtN == $past(protectLevel_reg)) else $error("wp stale"); // R15
  chk_busy_hold: assert property (@(posedge core_clk) disable iff (reset)
    (state_reg == ST_RECOVER && !rdySync_reg[1]) |=> state_reg == ST_RECOVER) else $error("left busy"); // R19
  chk_prot_select: assert property (@(posedge core_clk) disable iff (reset) // R14
    pins.highVoltReset |-> flashAddr[PROT_SEL_BIT] == (op_reg == OP_UNPROTECT)) else $error("protect direction");
  chk_idle_quiet: assert property (@(posedge core_clk) disable iff (reset) // R18
    (state_reg == ST_IDLE) |-> (pins.chipSelN && dataOe[14:0] == 15'h0000)) else $error("idle not quiet");
  chk_reset_hold: assert property (@(posedge core_clk) disable iff (reset) // R17
    (state_reg == ST_RESET) |-> (!pins.resetN && pins.chipSelN)) else $error("reset pin released");
  chk_recover_quiet: assert property (@(posedge core_clk) disable iff (reset) // R19
    (state_reg == ST_RECOVER) |-> (pins.chipSelN && pins.resetN)) else $error("access in recovery");
  chk_word_lanes: assert property (@(posedge core_clk) disable iff (reset) // R6
    (!pins.writeStrobeN && pins.byteModeN) |-> dataOe == 16'hFFFF) else $error("word lanes idle");

  // sequencing checks: a phase keeps its strobe until the count runs out
  chk_read_hold: assert property (@(posedge core_clk) disable iff (reset) // R1
    (state_reg == ST_READ && !cntDone) |=> !pins.outEnN) else $error("read cut short");
  chk_write_hold: assert property (@(posedge core_clk) disable iff (reset) // R2
    (state_reg inside {ST_WRITE, ST_PROT} && !cntDone) |=> !pins.writeStrobeN) else $error("write cut short");
endmodule : nor_flash_host
`default_nettype wire

// *** sim/nor_flash_model.sv ***
// behavioural parallel flash answering the host controller's pins
`timescale 1ns/1ps
`default_nettype none
module nor_flash_model
  import nor_bus_pkg::*;
(
  input wire ctrl_pins_t pins,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic [DATA_W-1:0] dataOut,
  output logic [DATA_W-1:0] dataIn,
  output logic ready_busy_n
);
  logic [7:0] mem [0:255];
  logic [7:0] bIdx;
  logic [DATA_W-1:0] flt;
  logic rdEn;
  logic protSel;
  logic [3:0] protLow;
  logic wrAct;
  logic wrHv;
  logic wrOk;
  logic wrWide;
  logic [7:0] wrIdx;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  // preload so reads need no command first; floating lines change every 4 ns
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3C;
    flt = 16'hA5A5;
    ready_busy_n = 1'b1;
    forever #4 flt = ~flt;
  end
  // byte mode takes the byte lsb from the top data pin
  assign bIdx = pins.byteModeN ? {flashAddr[6:0], 1'b0} : {flashAddr[6:0], dataOut[15]};
  // drive only in a legal read; reset, standby, disable and odd mixes float
  assign rdEn = !pins.chipSelN && !pins.outEnN && pins.writeStrobeN && pins.resetN;
  assign dataIn = !rdEn ? flt : pins.byteModeN ? {mem[bIdx+8'h01], mem[bIdx]} : {flt[15:8], mem[bIdx]};
  // a write cycle is select and strobe low with output enable high
  assign wrAct = !pins.chipSelN && pins.outEnN && !pins.writeStrobeN;
  // command latches: address, mode and data taken just after the strobe falls, applied as it rises;
  // the host releases select and strobe on one edge, so their levels are gone by the trailing edge
  always @(posedge wrAct) begin
    #1;
    wrHv = pins.highVoltReset && pins.writeProtN;
    wrOk = pins.resetN;
    wrAddr = flashAddr;
    wrIdx = bIdx;
    wrData = dataOut;
    wrWide = pins.byteModeN;
  end
  always @(negedge wrAct) begin
    if (wrHv === 1'b1) begin
      protSel = wrAddr[PROT_SEL_BIT];
      protLow = wrAddr[3:0];
    end else if (wrOk === 1'b1) begin
      mem[wrIdx] = wrData[7:0];
      if (wrWide) mem[wrIdx+8'h01] = wrData[15:8];
    end
  end
  // busy while held in reset and a short internal recovery after
  always @(pins.resetN) begin
    if (!pins.resetN) ready_busy_n = 1'b0;
    else ready_busy_n <= #40 1'b1;
  end
endmodule : nor_flash_model
`default_nettype wire

// *** sim/nor_flash_host_tb.sv ***
// self-checking bench for the flash bus host controller
`timescale 1ns/1ps
`default_nettype none
module nor_flash_host_tb;
  import nor_bus_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] busAddr = 4'h0;
  logic [31:0] busWrData = 32'h0;
  logic busWrite = 1'b0;
  logic busRead = 1'b0;
  logic [31:0] busRdData;
  ctrl_pins_t pins;
  logic [ADDR_W-1:0] flashAddr;
  logic [DATA_W-1:0] dataOut;
  logic [DATA_W-1:0] dataOe;
  logic [DATA_W-1:0] dataIn;
  logic ready_busy_n;
  logic [31:0] q;
  int failures = 0;
  int comparisons = 0;
  always #4 core_clk = ~core_clk;
  nor_flash_host u_dut (.core_clk(core_clk), .reset(reset), .busAddr(busAddr), .busWrData(busWrData),
    .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData), .pins(pins), .flashAddr(flashAddr),
    .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .ready_busy_n(ready_busy_n));
  nor_flash_model u_model (.pins(pins), .flashAddr(flashAddr), .dataOut(dataOut), .dataIn(dataIn),
    .ready_busy_n(ready_busy_n));
  task automatic test_done;
    $display("compares %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busWrData <= d;
    busWrite <= 1'b1;
    @(posedge core_clk);
    busWrite <= 1'b0;
  endtask : wr
  // read data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge core_clk);
    busRead <= 1'b0;
    #1 d = busRdData;
  endtask : rd
  task automatic waitIdle;
    logic [31:0] s;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 300; i++) begin
      rd(OFF_CTRL, s);
      if (s[6] === 1'b0) return;
    end
    failures++;
    $display("wrong value at %0t: busy never cleared", $time);
    test_done();
  endtask : waitIdle
  task automatic op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
    wr(OFF_ADDR, a);
    wr(OFF_WDATA, d);
    wr(OFF_CTRL, c);
    waitIdle();
  endtask : op
  // the host must never drive data while the flash may, nor mix both strobes low
  always @(posedge core_clk) begin
    if (!reset && !pins.outEnN && (|dataOe[14:0] || !pins.writeStrobeN)) begin
      failures++;
      $display("wrong value at %0t: contention on data or strobes", $time);
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    waitIdle();
    rd(OFF_CTRL, q);
    check({31'h0, q[7]}, 32'h1);
    rd(4'h2, q);
    check(q, 32'h0);
    op(32'hA, 32'h0, 32'h19);
    rd(OFF_RDATA, q);
    check({16'h0, q[15:0]}, 32'h3736);
    $display("test power-up read done");
    op(32'h14, 32'hBEEF, 32'h1A);
    op(32'h14, 32'h0, 32'h19);
    rd(OFF_RDATA, q);
    check({16'h0, q[15:0]}, 32'hBEEF);
    $display("test word program done");
    op(32'h33, 32'h7E, 32'h12);
    op(32'h33, 32'h0, 32'h11);
    rd(OFF_RDATA, q);
    check({24'h0, q[7:0]}, 32'h7E);
    op(32'h32, 32'h0, 32'h11);
    rd(OFF_RDATA, q);
    check({24'h0, q[7:0]}, 32'h0E);
    $display("test byte program done");
    op(32'h20000, 32'h0, 32'h13);
    check({27'h0, u_model.protSel, u_model.protLow}, 32'h02);
    op(32'h20000, 32'h0, 32'h14);
    check({27'h0, u_model.protSel, u_model.protLow}, 32'h12);
    $display("test protect done");
    wr(OFF_CTRL, 32'h30);
    waitIdle();
    op(32'h14, 32'h0, 32'h19);
    rd(OFF_RDATA, q);
    check({16'h0, q[15:0]}, 32'hBEEF);
    $display("test reset request done");
    test_done();
  end
endmodule : nor_flash_host_tb
`default_nettype wire
